/* src/acp_cfg.svh */
// Timing and sizing constants for the compressor protection block.
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH
`define ACP_CLK_NS        10
`define ACP_TICK_NS       1000000
`define ACP_TICK_CYC      (`ACP_TICK_NS / `ACP_CLK_NS)
`define ACP_MS_PER_S      1000
`define ACP_HOLD_S        15
`define ACP_DIAG_S        15
`define ACP_HP_RUN_S      10
`define ACP_WIN_S         60
`define ACP_FAN_HOLD_S    30
`define ACP_LAMP_S        30
`define ACP_MAX_STARTS    4
`define ACP_HP_TRIPS      4'h8
`define ACP_SLOW_ON_MS    16'h07D0
`define ACP_SLOW_OFF_MS   16'h00FA
`define ACP_FAST_MS       16'h00FA
`define ACP_SLOT_MS       16'h012C
`define ACP_SLOTS         4'hE
`define ACP_CODE_LP       3'h1
`define ACP_CODE_HP       3'h2
`define ACP_CODE_CLUTCH   3'h3
`define ACP_CODE_WIRE     3'h4
`define ACP_CODE_NONE     3'h0
`endif

/* src/acp_pkg.sv */
// Types shared by the compressor protection modules.
`include "acp_cfg.svh"
package acp_pkg;
  typedef enum logic [2:0] {ST_AMB, ST_HOLD, ST_DIAG, ST_RUN, ST_COLD} phase_t;
  typedef struct packed {
    logic lp_low;
    logic hp_high;
    logic lp_open;
    logic hp_open;
  } press_t;
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } div_t;
  typedef struct packed {
    logic [`ACP_MAX_STARTS-1:0][15:0] age;
    logic                             allow;
  } rate_t;
  typedef struct packed {
    phase_t      ph;
    logic [15:0] ph_ms;
    logic        clutch;
    logic        eng;
    logic        fan_gnd;
    logic [15:0] fan_ms;
    logic [15:0] hp_ms;
    logic        hp_block;
    logic [3:0]  hp_trips;
    logic        hp_fault;
    logic        lp_fault;
    logic        clutch_fault;
    logic [15:0] lamp_ms;
    logic        lamp_done;
    logic [15:0] blink_ms;
    logic [3:0]  slot;
    logic [15:0] g_ms;
    logic        g_tog;
    logic        red;
    logic        green;
  } core_t;
endpackage

/* src/acp_tick.sv */
// Divider that makes a one-cycle millisecond tick from the core clock.
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_tick
  import acp_pkg::*;
#(
  parameter int unsigned CYCLES = `ACP_TICK_CYC
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  output logic      tick_out
);
  div_t q;
  div_t d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == 24'(CYCLES - 1)) begin
      d.cnt  = 24'h000000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;
endmodule // acp_tick

/* src/acp_rate.sv */
// Start-rate limiter: remembers the age of the last few compressor starts.
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_rate
  import acp_pkg::*;
#(
  parameter int unsigned WIN_MS = `ACP_WIN_S * `ACP_MS_PER_S
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic tick_in,
  input  wire logic start_in,
  output logic      allow_out
);
  rate_t q;
  rate_t d;

  // A start is allowed only when the oldest remembered start is a full window old.
  always_comb begin
    d = q;
    if (start_in) begin
      for (int i = `ACP_MAX_STARTS - 1; i > 0; i--) begin
        d.age[i] = q.age[i-1];
      end
      d.age[0] = 16'h0000;
    end
    if (tick_in) begin
      for (int i = 0; i < `ACP_MAX_STARTS; i++) begin
        if (d.age[i] < 16'(WIN_MS)) begin
          d.age[i] = d.age[i] + 16'h0001;
        end
      end
    end
    d.allow = (d.age[`ACP_MAX_STARTS-1] >= 16'(WIN_MS));
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q.age   <= {`ACP_MAX_STARTS{16'(WIN_MS)}};
      q.allow <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign allow_out = q.allow;

  property p_rate;
    @(posedge clk_in) disable iff (!rstn_in)
    start_in |-> q.allow;
  endproperty
  a_rate: assert property (p_rate) else $error("Start made while rate limit closed.");
endmodule // acp_rate

/* src/acp_protect.sv */
// Compressor protection controller: clutch gating, fan request and blink codes.
// Functional notes
// - Clutch held off 15 s after ignition.
// - Then clutch forced on 15 s.
// - Diagnostic run stops on any pressure problem.
// - At most four starts per minute.
// - Thermostat switch drives clutch normally.
// - High pressure: clutch off within 10 s.
// - Restart after high pressure clears, rate permitting.
// - Low pressure: off now, restart when clear.
// - Low supply: off, restart when recovered.
// - Eight high-pressure trips per fan run latch off.
// - Fan requested by opening ground output.
// - Low pressure fault: one red blink.
// - High pressure fault: two red blinks.
// - Clutch circuit fault: three red blinks.
// - Pressure switch wiring open: four blinks.
// - Low supply: rapid green blink.
// - Green steady for first 30 s.
// - Closed low switch, open high switch mean fault.
// - Slow green: on 2 s, brief off.
// - Rapid green: toggles four times per second.
// - Clutch circuit checked only when engaging.
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_protect
  import acp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `ACP_TICK_CYC,
  parameter int unsigned HOLD_MS     = `ACP_HOLD_S * `ACP_MS_PER_S,
  parameter int unsigned DIAG_MS     = `ACP_DIAG_S * `ACP_MS_PER_S,
  parameter int unsigned HP_RUN_MS   = `ACP_HP_RUN_S * `ACP_MS_PER_S,
  parameter int unsigned WIN_MS      = `ACP_WIN_S * `ACP_MS_PER_S,
  parameter int unsigned FAN_HOLD_MS = `ACP_FAN_HOLD_S * `ACP_MS_PER_S,
  parameter int unsigned LAMP_MS     = `ACP_LAMP_S * `ACP_MS_PER_S
) (
  input  wire logic CORE_CLK_IN,
  input  wire logic RSTN_IN,
  input  wire logic AMBIENT_COLD_IN,
  input  wire logic COLD_REQ_IN,
  input  wire logic LP_SW_CLOSED_IN,
  input  wire logic HP_SW_CLOSED_IN,
  input  wire logic LP_WIRE_OPEN_IN,
  input  wire logic HP_WIRE_OPEN_IN,
  input  wire logic LOW_VOLT_IN,
  input  wire logic CLUTCH_SENSE_BAD_IN,
  output logic      CLUTCH_OUT,
  output logic      FAN_GND_OUT,
  output logic      RED_LED_OUT,
  output logic      GREEN_LED_OUT,
  output logic      HP_FAULT_OUT,
  output logic      CLUTCH_FAULT_OUT
);
  core_t  q;
  core_t  d;
  logic   tick;
  logic   allow;
  logic   start;
  press_t pr;
  logic   press_bad;
  logic   keep;
  logic   may_start;
  logic   run_req;
  logic   ph_end;
  logic [2:0] code;

  // Switch polarity: the low switch closes on low pressure, the high one opens on high pressure.
  function automatic press_t decode_press(input logic lp_closed, input logic hp_closed,
                                          input logic lp_open, input logic hp_open);
    press_t p;
    p.lp_low  = lp_closed & ~lp_open;
    p.hp_high = ~hp_closed & ~hp_open;
    p.lp_open = lp_open;
    p.hp_open = hp_open;
    return p;
  endfunction

  // Red blink code, most urgent fault first.
  function automatic logic [2:0] red_code(input core_t s, input press_t p);
    if (p.lp_open || p.hp_open) begin
      return `ACP_CODE_WIRE;
    end else if (s.clutch_fault) begin
      return `ACP_CODE_CLUTCH;
    end else if (s.hp_fault) begin
      return `ACP_CODE_HP;
    end else if (s.lp_fault) begin
      return `ACP_CODE_LP;
    end else begin
      return `ACP_CODE_NONE;
    end
  endfunction

  acp_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in   (CORE_CLK_IN),
    .rstn_in  (RSTN_IN),
    .tick_out (tick)
  );

  acp_rate #(
    .WIN_MS (WIN_MS)
  ) u_rate (
    .clk_in    (CORE_CLK_IN),
    .rstn_in   (RSTN_IN),
    .tick_in   (tick),
    .start_in  (start),
    .allow_out (allow)
  );

  always_comb begin
    d         = q;
    pr        = decode_press(LP_SW_CLOSED_IN, HP_SW_CLOSED_IN, LP_WIRE_OPEN_IN, HP_WIRE_OPEN_IN);
    press_bad = pr.lp_low | pr.hp_high | pr.lp_open | pr.hp_open;
    ph_end    = 1'b0;
    run_req   = 1'b0;
    keep      = 1'b0;
    may_start = 1'b0;
    code      = red_code(q, pr);

    // Ignition sequence: ambient check, hold-off, forced diagnostic run, then normal running.
    case (q.ph)
      ST_AMB: begin
        d.ph = AMBIENT_COLD_IN ? ST_COLD : ST_HOLD;
      end
      ST_HOLD: begin
        if (tick) begin
          ph_end  = (q.ph_ms == 16'(HOLD_MS - 1));
          d.ph_ms = ph_end ? 16'h0000 : q.ph_ms + 16'h0001;
          d.ph    = ph_end ? ST_DIAG : ST_HOLD;
        end
      end
      ST_DIAG: begin
        run_req = 1'b1;
        if (press_bad) begin
          d.ph    = ST_RUN;
          d.ph_ms = 16'h0000;
          run_req = 1'b0;
        end else if (tick) begin
          ph_end  = (q.ph_ms == 16'(DIAG_MS - 1));
          d.ph_ms = ph_end ? 16'h0000 : q.ph_ms + 16'h0001;
          d.ph    = ph_end ? ST_RUN : ST_DIAG;
        end
      end
      ST_RUN: begin
        run_req = COLD_REQ_IN;
      end
      ST_COLD: begin
        run_req = 1'b0;
      end
      default: begin
        d.ph = ST_AMB;
      end
    endcase

    // A running clutch may ride out high pressure for a while; a new start needs every switch normal.
    keep = run_req & ~LOW_VOLT_IN & ~pr.lp_low & ~pr.lp_open & ~pr.hp_open
         & ~q.hp_block & ~q.hp_fault & ~q.clutch_fault;
    may_start = keep & ~pr.hp_high & allow;
    d.clutch  = q.clutch ? keep : may_start;
    start     = d.clutch & ~q.clutch;
    d.eng     = start;

    // The clutch circuit is judged only in the cycle right after engagement.
    if (q.eng && q.clutch && CLUTCH_SENSE_BAD_IN) begin
      d.clutch_fault = 1'b1;
    end

    if ((q.ph == ST_RUN || q.ph == ST_DIAG) && pr.lp_low) begin
      d.lp_fault = 1'b1;
    end

    // High-pressure run timer and trip counting.
    if (!pr.hp_high) begin
      d.hp_ms    = 16'h0000;
      d.hp_block = 1'b0;
    end else if (q.clutch && tick && !q.hp_block) begin
      if (q.hp_ms == 16'(HP_RUN_MS - 1)) begin
        d.hp_block = 1'b1;
        d.hp_ms    = 16'h0000;
        d.hp_trips = q.hp_trips + 4'h1;
      end else begin
        d.hp_ms = q.hp_ms + 16'h0001;
      end
    end
    if (d.hp_trips == `ACP_HP_TRIPS) begin
      d.hp_fault = 1'b1;
    end

    // Fan run: ground opens on high pressure and stays open for a hold time after it clears.
    if (pr.hp_high) begin
      d.fan_gnd = 1'b0;
      d.fan_ms  = 16'(FAN_HOLD_MS);
    end else if (!q.fan_gnd && tick) begin
      if (q.fan_ms == 16'h0000) begin
        d.fan_gnd  = 1'b1;
        d.hp_trips = 4'h0;
      end else begin
        d.fan_ms = q.fan_ms - 16'h0001;
      end
    end

    // Red groups run over slots; odd slots are gaps and the unused slots form the pause.
    if (tick) begin
      if (q.blink_ms == `ACP_SLOT_MS - 16'h0001) begin
        d.blink_ms = 16'h0000;
        d.slot     = (q.slot == `ACP_SLOTS - 4'h1) ? 4'h0 : q.slot + 4'h1;
      end else begin
        d.blink_ms = q.blink_ms + 16'h0001;
      end
    end
    d.red = (code != `ACP_CODE_NONE) && !q.slot[0] && ({1'b0, q.slot[3:1]} < {1'b0, code});

    // Green pattern counter: short toggle period when the supply is low, long cycle otherwise.
    if (tick) begin
      if (LOW_VOLT_IN) begin
        if (q.g_ms >= `ACP_FAST_MS - 16'h0001) begin
          d.g_ms  = 16'h0000;
          d.g_tog = ~q.g_tog;
        end else begin
          d.g_ms = q.g_ms + 16'h0001;
        end
      end else if (q.g_ms >= `ACP_SLOW_ON_MS + `ACP_SLOW_OFF_MS - 16'h0001) begin
        d.g_ms = 16'h0000;
      end else begin
        d.g_ms = q.g_ms + 16'h0001;
      end
      if (!q.lamp_done) begin
        d.lamp_ms   = q.lamp_ms + 16'h0001;
        d.lamp_done = (q.lamp_ms == 16'(LAMP_MS - 1));
      end
    end

    if (!q.lamp_done) begin
      d.green = 1'b1;
    end else if (LOW_VOLT_IN) begin
      d.green = q.g_tog;
    end else if (code != `ACP_CODE_NONE) begin
      d.green = 1'b0;
    end else begin
      d.green = (q.g_ms < `ACP_SLOW_ON_MS);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      q         <= '0;
      q.ph      <= ST_AMB;
      q.fan_gnd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign CLUTCH_OUT       = q.clutch;
  assign FAN_GND_OUT      = q.fan_gnd;
  assign RED_LED_OUT      = q.red;
  assign GREEN_LED_OUT    = q.green;
  assign HP_FAULT_OUT     = q.hp_fault;
  assign CLUTCH_FAULT_OUT = q.clutch_fault;

  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  property p_hold;
    (q.ph == ST_HOLD || q.ph == ST_AMB || q.ph == ST_COLD) |-> !q.clutch;
  endproperty
  a_hold: assert property (p_hold) else $error("Clutch on before diagnostic run.");

  property p_diag_on;
    (q.ph == ST_DIAG && !press_bad && !LOW_VOLT_IN && allow && !q.clutch_fault) |=> q.clutch;
  endproperty
  a_diag_on: assert property (p_diag_on) else $error("Diagnostic run did not engage clutch.");

  property p_diag_drop;
    (q.ph == ST_DIAG && press_bad) |=> (!q.clutch && q.ph == ST_RUN);
  endproperty
  a_diag_drop: assert property (p_diag_drop) else $error("Diagnostic run kept going on bad pressure.");

  property p_lp;
    (pr.lp_low || pr.lp_open) |=> !q.clutch;
  endproperty
  a_lp: assert property (p_lp) else $error("Clutch on with low pressure.");

  property p_lv;
    LOW_VOLT_IN |=> !q.clutch;
  endproperty
  a_lv: assert property (p_lv) else $error("Clutch on with low supply.");

  property p_hp_run;
    (q.clutch && q.hp_block) |=> !q.clutch;
  endproperty
  a_hp_run: assert property (p_hp_run) else $error("Clutch held past high-pressure limit.");

  property p_hp_ms;
    q.hp_ms < 16'(HP_RUN_MS);
  endproperty
  a_hp_ms: assert property (p_hp_ms) else $error("High-pressure timer overran.");

  property p_hp_latch;
    q.hp_fault |=> (q.hp_fault && !q.clutch);
  endproperty
  a_hp_latch: assert property (p_hp_latch) else $error("High-pressure latch released.");

  property p_fan;
    pr.hp_high |=> !q.fan_gnd;
  endproperty
  a_fan: assert property (p_fan) else $error("Fan ground not opened on high pressure.");

  property p_clf;
    $rose(q.clutch_fault) |-> $past(q.eng);
  endproperty
  a_clf: assert property (p_clf) else $error("Clutch fault flagged outside engagement.");

  property p_idle;
    (q.lamp_done && !LOW_VOLT_IN && code == `ACP_CODE_NONE) |=> !q.red;
  endproperty
  a_idle: assert property (p_idle) else $error("Red lamp lit with no fault.");

  property p_lamp;
    !q.lamp_done |=> q.green;
  endproperty
  a_lamp: assert property (p_lamp) else $error("Green not steady during start-up.");

  property p_run_off;
    (q.ph == ST_RUN && !COLD_REQ_IN) |=> !q.clutch;
  endproperty
  a_run_off: assert property (p_run_off) else $error("Clutch on without thermostat request.");

  property p_hp_start;
    (!q.clutch && pr.hp_high) |=> !q.clutch;
  endproperty
  a_hp_start: assert property (p_hp_start) else $error("Clutch started during high pressure.");

  property p_fast;
    (q.lamp_done && LOW_VOLT_IN) |=> (q.green == $past(q.g_tog));
  endproperty
  a_fast: assert property (p_fast) else $error("Green not following fast pattern on low supply.");

  property p_cold_stay;
    (q.ph == ST_COLD) |=> (q.ph == ST_COLD && !q.clutch);
  endproperty
  a_cold_stay: assert property (p_cold_stay) else $error("Cold start lock released.");
endmodule // acp_protect

/* verif/acp_partner.sv */
// Behavioural model of the switches, clutch coil and fan solenoid around the controller.
`timescale 1ns/1ps
module acp_partner (
  input  wire logic clutch_in,
  input  wire logic fan_gnd_in,
  input  wire logic lp_low_in,
  input  wire logic hp_high_in,
  input  wire logic coil_bad_in,
  output logic      lp_closed_out,
  output logic      hp_closed_out,
  output logic      sense_bad_out,
  output logic      fan_on_out
);
  // A low charge closes the low switch, while excess head pressure opens the high switch.
  assign lp_closed_out = lp_low_in;
  assign hp_closed_out = ~hp_high_in;
  // A damaged coil only shows on the sense line while it is being driven.
  assign sense_bad_out = clutch_in & coil_bad_in;
  // The solenoid releases the fan when its ground is opened.
  assign fan_on_out = ~fan_gnd_in;
endmodule // acp_partner

/* verif/testbench.sv */
// Self-checking bench for the compressor protection controller.
`timescale 1ns/1ps
module testbench;
  import acp_pkg::*;
  localparam int TK   = 4;
  localparam int HOLD = 5;
  localparam int DIAG = 5;
  localparam int HPR  = 4;
  localparam int WIN  = 40;
  localparam int FANH = 10;
  localparam int PER  = 14 * 300 * TK;
  localparam int CL   = 0;
  localparam int FG   = 1;
  localparam int RD   = 2;
  localparam int GR   = 3;
  localparam int CF   = 5;

  logic clk      = 1'h0;
  logic rstn     = 1'h0;
  logic amb_cold = 1'h0;
  logic cold_req = 1'h0;
  logic lp_low   = 1'h0;
  logic hp_high  = 1'h0;
  logic lp_wire  = 1'h0;
  logic hp_wire  = 1'h0;
  logic low_volt = 1'h0;
  logic coil_bad = 1'h0;
  logic lp_closed;
  logic hp_closed;
  logic sense_bad;
  logic fan_on;
  logic clutch;
  logic fan_gnd;
  logic red;
  logic green;
  logic hp_fault;
  logic clutch_fault;
  int   fail_count = 0;
  int   n_compared = 0;
  int   red_hi     = 0;
  wire  [5:0] o    = {clutch_fault, hp_fault, green, red, fan_gnd, clutch};

  always #5 clk = ~clk;

  acp_protect #(
    .TICK_CYCLES (TK),
    .HOLD_MS     (HOLD),
    .DIAG_MS     (DIAG),
    .HP_RUN_MS   (HPR),
    .WIN_MS      (WIN),
    .FAN_HOLD_MS (FANH),
    .LAMP_MS     (6)
  ) DUT (
    .CORE_CLK_IN         (clk),
    .RSTN_IN             (rstn),
    .AMBIENT_COLD_IN     (amb_cold),
    .COLD_REQ_IN         (cold_req),
    .LP_SW_CLOSED_IN     (lp_closed),
    .HP_SW_CLOSED_IN     (hp_closed),
    .LP_WIRE_OPEN_IN     (lp_wire),
    .HP_WIRE_OPEN_IN     (hp_wire),
    .LOW_VOLT_IN         (low_volt),
    .CLUTCH_SENSE_BAD_IN (sense_bad),
    .CLUTCH_OUT          (clutch),
    .FAN_GND_OUT         (fan_gnd),
    .RED_LED_OUT         (red),
    .GREEN_LED_OUT       (green),
    .HP_FAULT_OUT        (hp_fault),
    .CLUTCH_FAULT_OUT    (clutch_fault)
  );

  acp_partner far_side (
    .clutch_in     (clutch),
    .fan_gnd_in    (fan_gnd),
    .lp_low_in     (lp_low),
    .hp_high_in    (hp_high),
    .coil_bad_in   (coil_bad),
    .lp_closed_out (lp_closed),
    .hp_closed_out (hp_closed),
    .sense_bad_out (sense_bad),
    .fan_on_out    (fan_on)
  );

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Steps n edges and lands just after the last one, where outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_for(input int k, input logic v, input int n);
    int i;
    i = 0;
    while (o[k] !== v && i < n) begin
      cyc(1);
      i++;
    end
    chk(16'(o[k]), 16'(v));
  endtask

  task automatic hold(input int k, input logic v, input int n);
    logic ok;
    ok = 1'h1;
    repeat (n) begin
      cyc(1);
      if (o[k] !== v)
        ok = 1'h0;
    end
    chk(16'(ok), 16'h0001);
  endtask

  // Counts rising edges and high cycles of one output; red high cycles are tallied too.
  task automatic watch(input int k, input int n, output int rs, output int hi);
    logic last;
    last = o[k];
    rs = 0;
    hi = 0;
    repeat (n) begin
      cyc(1);
      if (o[k] === 1'h1 && last !== 1'h1)
        rs++;
      if (o[k] === 1'h1)
        hi++;
      if (red === 1'h1)
        red_hi++;
      last = o[k];
    end
  endtask

  task automatic restart(input logic cold);
    rstn = 1'h0;
    amb_cold = cold;
    {cold_req, lp_low, hp_high, lp_wire, hp_wire, low_volt, coil_bad} = 7'h00;
    cyc(12);
    chk(16'(o), 16'h0002);
    rstn = 1'h1;
    cyc(2);
    chk(16'(green), 16'h0001);
  endtask

  initial begin : main
    int r;
    int h;
    int i;
    int k;
    restart(1'h1);
    cold_req = 1'h1;
    hold(CL, 1'h0, 200);
    restart(1'h0);
    cold_req = 1'h1;
    hold(CL, 1'h0, HOLD * TK - TK);
    wait_for(CL, 1'h1, 3 * TK);
    cold_req = 1'h0;
    hold(CL, 1'h1, DIAG * TK - 2 * TK);
    wait_for(CL, 1'h0, 3 * TK);
    cold_req = 1'h1;
    wait_for(CL, 1'h1, 3);
    k = 0;
    repeat (20) begin
      cold_req = ~cold_req;
      watch(CL, 4, r, h);
      k += r;
    end
    chk(16'(k), 16'h0002);
    cold_req = 1'h1;
    wait_for(CL, 1'h1, WIN * TK + 3 * TK);
    hp_high = 1'h1;
    cyc(2);
    chk(16'(fan_on), 16'h0001);
    wait_for(CL, 1'h0, (HPR + 2) * TK);
    hp_high = 1'h0;
    wait_for(CL, 1'h1, WIN * TK + 3 * TK);
    wait_for(FG, 1'h1, (FANH + 3) * TK);
    lp_low = 1'h1;
    wait_for(CL, 1'h0, 2);
    // Let the fault code reach the lamp so the window holds exactly one group start.
    cyc(2);
    watch(RD, PER, r, h);
    chk(16'(r), 16'h0001);
    lp_low = 1'h0;
    wait_for(CL, 1'h1, 3 * TK);
    low_volt = 1'h1;
    wait_for(CL, 1'h0, 2);
    cyc(2000);
    watch(GR, 4000, r, h);
    chk(16'(r), 16'h0002);
    chk(16'(h), 16'h07D0);
    low_volt = 1'h0;
    wait_for(CL, 1'h1, WIN * TK + 3 * TK);
    restart(1'h0);
    cyc(1000);
    red_hi = 0;
    watch(GR, 9000, r, h);
    chk(16'(r), 16'h0001);
    chk(16'(h), 16'h1F40);
    chk(16'(red_hi), 16'h0000);
    restart(1'h0);
    cold_req = 1'h1;
    wait_for(CL, 1'h1, (HOLD + 3) * TK);
    cyc(DIAG * TK + TK);
    for (i = 0; i < 8; i++) begin
      k = 0;
      while (clutch !== 1'h1 && k < 40) begin
        hp_high = 1'h0;
        cyc(6);
        if (clutch !== 1'h1) begin
          hp_high = 1'h1;
          cyc(4);
        end
        k++;
      end
      hp_high = 1'h1;
      wait_for(CL, 1'h0, (HPR + 2) * TK);
    end
    chk(16'(hp_fault), 16'h0001);
    hp_high = 1'h0;
    hold(CL, 1'h0, WIN * TK + 40);
    watch(RD, PER, r, h);
    chk(16'(r), 16'h0002);
    restart(1'h0);
    wait_for(CL, 1'h1, (HOLD + 3) * TK);
    // The coil fails only after the engagement check cycle has passed.
    cyc(1);
    coil_bad = 1'h1;
    hold(CF, 1'h0, DIAG * TK - 2 * TK);
    wait_for(CL, 1'h0, 3 * TK);
    cold_req = 1'h1;
    wait_for(CF, 1'h1, 6);
    wait_for(CL, 1'h0, 2);
    watch(RD, PER, r, h);
    chk(16'(r), 16'h0003);
    restart(1'h0);
    wait_for(CL, 1'h1, (HOLD + 3) * TK);
    lp_wire = 1'h1;
    wait_for(CL, 1'h0, 2);
    watch(RD, PER, r, h);
    chk(16'(r), 16'h0004);
    chk(16'(h), 16'h12C0);
    final_report();
  end

  initial begin : watchdog
    cyc(95000);
    fail_count++;
    final_report();
  end
endmodule // testbench
